// ---- spi_master_slave_port.sv ----
// byte-wide full-duplex serial port, master or slave, with an apb register slave
//
// Overview of operation
// - miso is an input as master, an output as slave, msb first
// - slave drives miso only while its slave select is low
// - mosi is an output as master, an input as slave, msb first
// - one byte is exchanged over eight sck cycles; slave takes sck as input
// - polarity and phase pick one of four clock-to-data relations on both ends
// - master puts each bit on mosi half a period before the sampling edge
// - rate select bits only act in master mode
// - master with slave select pulled low sets the mode fault flag
// - direction bit 5 turns slave select of a master into a plain output, no fault check
// - phase zero: slave select frames each byte and rises between bytes
// - phase one: slave select may stay low over many bytes
// - full duplex: sent byte is replaced by received byte, one done flag
// - receive is double buffered; a write during a transfer collides and is dropped
// - done flag sets once a full byte has shifted
// - master sck idles until data written, then exactly eight clocks
// - slave shifts mosi in on master clock, full byte goes to read buffer
// - slave write loads shift register and waits for master clocks
// - alternate option: an output pin joins the port only with its direction bit set
// - enabled port keeps its input lines as inputs regardless of direction bits
// - interrupt enable gates the request and clears on reset
// - master rate at most clk over 2; slave up to the bus clock, but here each slave sck level must last two clk cycles (clk over 4)
// - mode fault clears system enable and master select
// - rate codes divide clk by 2, 4, 16 and 32
// - done clears on status read with done set, then a data access
// - master sck idles low with polarity clear, high with it set
//
// The APB register port and the register addresses are this design's own decisions.
module spi_master_slave_port #(
    parameter bit ALT_CONFIG = 1'b1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [3:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sck_i,
    output logic sck_o,
    output logic sck_oe,
    input wire logic mosi_i,
    output logic mosi_o,
    output logic mosi_oe,
    input wire logic miso_i,
    output logic miso_o,
    output logic miso_oe,
    input wire logic ss_n_i,
    output logic ss_n_o,
    output logic ss_n_oe,
    output logic irq,
    output spi_port_pkg::rate_t rate_sel
);
    import spi_port_pkg::*;
    `include "spi_port_params.svh"

    port_state_s st_r;
    port_state_s st_nxt;
    logic [3:0] pin_s;
    logic ss_s, sck_s, mosi_s, miso_s;
    logic acc, setup, wr, rd;
    logic hit_ctrl, hit_stat, hit_data, hit_ddr;
    logic en_m, en_s, ss_gp, mode_fault_flag_det, busy;
    logic mtick, sl_chg, lead, trail, smp_edge, shf_edge, last, din, m_fin;
    logic data_ok, data_col;
    logic [7:0] nb;

    function automatic logic addr_is(input logic [3:0] a, input logic [3:0] ofs);
        addr_is = (a == ofs);
    endfunction

    function automatic logic [4:0] rate_half(input rate_t r);
        unique case (r)
            2'b00: rate_half = `HALF_RATE0;
            2'b01: rate_half = `HALF_RATE1;
            2'b10: rate_half = `HALF_RATE2;
            2'b11: rate_half = `HALF_RATE3;
        endcase
    endfunction

    // an output pin only reaches the port when its direction bit allows it
    function automatic logic dir_ok(input logic d);
        dir_ok = !ALT_CONFIG || d;
    endfunction

    // pins from the far side are synchronised before any edge logic sees them
    spi_pin_sync #(
        .WIDTH(4)
    ) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({miso_i, mosi_i, sck_i, ss_n_i}),
        .pin_out(pin_s)
    );

    assign ss_s = pin_s[0];
    assign sck_s = pin_s[1];
    assign mosi_s = pin_s[2];
    assign miso_s = pin_s[3];

    // apb decode; zero wait states, so pready is held high
    assign setup = psel && !penable;
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign rd = acc && !pwrite;
    assign hit_ctrl = addr_is(paddr, `OFS_CTRL);
    assign hit_stat = addr_is(paddr, `OFS_STAT);
    assign hit_data = addr_is(paddr, `OFS_DATA);
    assign hit_ddr = addr_is(paddr, `OFS_DDR);
    assign pready = 1'b1;
    assign pslverr = acc && !(hit_ctrl || hit_stat || hit_data || hit_ddr);

    // role and fault detection
    assign en_m = st_r.sys_en && st_r.master;
    assign en_s = st_r.sys_en && !st_r.master;
    assign ss_gp = ALT_CONFIG && st_r.ddr[`DDR_SS_BIT];
    assign mode_fault_flag_det = en_m && !ss_s && !ss_gp;

    // master edges come from the divider, slave edges from the synchronised pin
    assign mtick = (st_r.mst == ST_RUN) && (st_r.div == 5'h00);
    assign sl_chg = en_s && !ss_s && (sck_s != st_r.sck_q);
    assign lead = (mtick && !st_r.cnt[0]) || (sl_chg && (sck_s ^ st_r.clock_polarity));
    assign trail = (mtick && st_r.cnt[0]) || (sl_chg && !(sck_s ^ st_r.clock_polarity));
    assign smp_edge = st_r.clock_phase ? trail : lead;
    assign shf_edge = st_r.clock_phase ? lead : trail;
    assign last = (st_r.cnt == 4'hF);
    assign din = st_r.master ? miso_s : mosi_s;
    assign m_fin = mtick && last && !mode_fault_flag_det;
    assign nb = smp_edge ? {st_r.sh[6:0], din} : {st_r.sh[6:0], st_r.sample};

    // phase zero slave is busy while selected; phase one from its first edge to done
    assign busy = st_r.master ? (st_r.mst == ST_RUN)
                : (en_s && !ss_s && (!st_r.clock_phase || st_r.cnt != 4'h0));
    // after a byte, data writes are dropped until software has read the status with done set
    assign data_col = wr && hit_data && busy;
    assign data_ok = wr && hit_data && !busy && !(st_r.done && !st_r.done_arm);

    // all next-state logic; later steps override earlier ones so set beats clear
    always_comb begin
        st_nxt = st_r;
        // control and direction writes
        if (wr && hit_ctrl) begin
            st_nxt.irq_en = pwdata[`CTRL_IRQ_EN];
            st_nxt.sys_en = pwdata[`CTRL_SYS_EN];
            st_nxt.master = pwdata[`CTRL_MASTER];
            st_nxt.clock_polarity = pwdata[`CTRL_CLOCK_POLARITY];
            st_nxt.clock_phase = pwdata[`CTRL_CLOCK_PHASE];
            st_nxt.rate = {pwdata[`CTRL_RATE_HI], pwdata[`CTRL_RATE_LO]};
            if (st_r.mode_fault_flag_arm) begin
                st_nxt.mode_fault_flag = 1'b0;
                st_nxt.mode_fault_flag_arm = 1'b0;
            end
        end
        if (wr && hit_ddr) begin
            st_nxt.ddr = pwdata[7:0];
        end
        // a status read arms the clearing of each flag it saw set
        if (rd && hit_stat) begin
            st_nxt.done_arm = st_r.done || st_r.done_arm;
            st_nxt.write_collision_flag_arm = st_r.write_collision_flag || st_r.write_collision_flag_arm;
            st_nxt.mode_fault_flag_arm = st_r.mode_fault_flag || st_r.mode_fault_flag_arm;
        end
        // any data access completes an armed clear
        if (acc && hit_data) begin
            if (st_r.done_arm) begin
                st_nxt.done = 1'b0;
                st_nxt.done_arm = 1'b0;
            end
            if (st_r.write_collision_flag_arm) begin
                st_nxt.write_collision_flag = 1'b0;
                st_nxt.write_collision_flag_arm = 1'b0;
            end
        end
        // writes go straight into the shift register, never buffered
        if (data_ok) begin
            st_nxt.sh = pwdata[7:0];
            if (en_m) begin
                st_nxt.mst = ST_RUN;
                st_nxt.cnt = 4'h0;
                st_nxt.div = rate_half(st_r.rate) - 5'h01;
            end
        end
        if (data_col) begin
            st_nxt.write_collision_flag = 1'b1;
        end
        // sample and shift; phase one delays each shift except the last to the next leading edge
        if (smp_edge) begin
            if (last) begin
                st_nxt.sh = nb;
            end else begin
                st_nxt.sample = din;
            end
        end
        if (shf_edge && (last || st_r.cnt != 4'h0)) begin
            st_nxt.sh = nb;
        end
        if (lead || trail) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
        end
        // byte complete: copy to the read buffer unless the last byte is unread
        if ((lead || trail) && last) begin
            if (!st_nxt.done) begin
                st_nxt.rxbuf = nb;
            end
            st_nxt.done = 1'b1;
        end
        // master clock divider and sck train
        if (st_r.mst == ST_RUN) begin
            if (mtick) begin
                st_nxt.div = rate_half(st_r.rate) - 5'h01;
                st_nxt.sck_lvl = !st_r.sck_lvl;
                if (last) begin
                    st_nxt.mst = ST_IDLE;
                end
            end else begin
                st_nxt.div = st_r.div - 5'h01;
            end
        end else begin
            st_nxt.sck_lvl = st_r.clock_polarity;
        end
        if (!en_m) begin
            st_nxt.mst = ST_IDLE;
        end
        // a deselected slave starts its next byte from bit seven
        if (!st_r.master && (ss_s || !st_r.sys_en)) begin
            st_nxt.cnt = 4'h0;
        end
        // mode fault wins over a control write in the same cycle
        if (mode_fault_flag_det) begin
            st_nxt.mode_fault_flag = 1'b1;
            st_nxt.sys_en = 1'b0;
            st_nxt.master = 1'b0;
            st_nxt.mst = ST_IDLE;
            st_nxt.sck_lvl = st_r.clock_polarity;
        end
        st_nxt.sck_q = sck_s;
        // read data is captured in the setup cycle so it comes from a flop
        if (setup && !pwrite) begin
            st_nxt.prdata = 32'h0000_0000;
            if (hit_ctrl) begin
                st_nxt.prdata[7:0] = {st_r.irq_en, st_r.sys_en, 1'b0, st_r.master,
                                      st_r.clock_polarity, st_r.clock_phase, st_r.rate};
            end
            if (hit_stat) begin
                st_nxt.prdata[7:0] = {st_r.done, st_r.write_collision_flag, 1'b0, st_r.mode_fault_flag, 4'h0};
            end
            if (hit_data) begin
                st_nxt.prdata[7:0] = st_r.rxbuf;
            end
            if (hit_ddr) begin
                st_nxt.prdata[7:0] = st_r.ddr;
            end
        end
    end

    // single state register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
            st_r.ddr <= `DDR_RESET;
            st_r.sck_q <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    // pin drivers; input lines never get an enable in their role
    assign sck_o = st_r.sck_lvl;
    assign sck_oe = en_m && dir_ok(st_r.ddr[`DDR_SCK_BIT]);
    assign mosi_o = st_r.sh[7];
    assign mosi_oe = en_m && dir_ok(st_r.ddr[`DDR_MOSI_BIT]);
    assign miso_o = st_r.sh[7];
    assign miso_oe = en_s && !ss_s && dir_ok(st_r.ddr[`DDR_MISO_BIT]);
    assign ss_n_o = st_r.ddr[`DDR_SS_LEVEL];
    assign ss_n_oe = ss_gp && st_r.master;
    assign irq = st_r.irq_en && (st_r.done || st_r.mode_fault_flag);
    assign prdata = st_r.prdata;
    assign rate_sel = st_r.rate;

    // sck toggle counter for the master train, read only by the checks below
    logic [4:0] tgl_r;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tgl_r <= 5'h00;
        end else if (data_ok && en_m) begin
            tgl_r <= 5'h00;
        end else if (st_r.mst == ST_RUN && st_nxt.sck_lvl != st_r.sck_lvl) begin
            tgl_r <= tgl_r + 5'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_idle2;
        (st_r.mst == ST_IDLE) [*2];
    endsequence

    sequence s_next_change_or_idle;
        $changed(sck_o) || st_r.mst == ST_IDLE;
    endsequence

    property p_miso_hiz;
        (en_s && ss_s) |-> !miso_oe;
    endproperty
    a_miso_hiz: assert property (p_miso_hiz) else $error("miso driven while deselected");

    property p_mosi_role;
        mosi_oe |-> (st_r.master && st_r.sys_en);
    endproperty
    a_mosi_role: assert property (p_mosi_role) else $error("mosi driven outside master");

    property p_idle_level;
        s_idle2 |-> (sck_o == $past(st_r.clock_polarity));
    endproperty
    a_idle_level: assert property (p_idle_level) else $error("sck not at idle level");

    property p_mode_fault_flag;
        mode_fault_flag_det |=> (st_r.mode_fault_flag && !st_r.sys_en && !st_r.master && !sck_oe);
    endproperty
    a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not handled");

    property p_write_collision_flag;
        (data_col && !(mtick && last) && !mode_fault_flag_det) |=> (st_r.write_collision_flag && $past(st_r.mst) == st_r.mst);
    endproperty
    a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

    property p_done;
        ((lead || trail) && last) |=> st_r.done;
    endproperty
    a_done: assert property (p_done) else $error("done not set after byte");

    property p_eight;
        m_fin |=> (tgl_r == 5'h10 && st_r.mst == ST_IDLE);
    endproperty
    a_eight: assert property (p_eight) else $error("master train not eight clocks");

    property p_rate_div4;
        (st_r.mst == ST_RUN && st_r.rate == 2'b01 && $changed(sck_o))
            |=> $stable(sck_o) ##1 s_next_change_or_idle;
    endproperty
    a_rate_div4: assert property (p_rate_div4) else $error("divide by 4 timing wrong");

    property p_rate_div16;
        (st_r.mst == ST_RUN && st_r.rate == 2'b10 && $changed(sck_o))
            |=> $stable(sck_o) [*7] ##1 s_next_change_or_idle;
    endproperty
    a_rate_div16: assert property (p_rate_div16) else $error("divide by 16 timing wrong");

    property p_rxbuf;
        ((lead || trail) && last && !st_r.done) |=> (st_r.rxbuf == st_r.sh);
    endproperty
    a_rxbuf: assert property (p_rxbuf) else $error("read buffer not loaded");

    property p_irq_gate;
        (wr && hit_ctrl) |=> (st_r.irq_en == $past(pwdata[`CTRL_IRQ_EN]));
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt enable not written");

endmodule // spi_master_slave_port

// ---- spi_port_params.svh ----
// register map, field positions, reset values and rate counts of the serial port
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// word offsets on the register bus
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4
`define OFS_DATA 4'h8
`define OFS_DDR 4'hC

// control register bit positions
`define CTRL_IRQ_EN 7
`define CTRL_SYS_EN 6
`define CTRL_MASTER 4
`define CTRL_CLOCK_POLARITY 3
`define CTRL_CLOCK_PHASE 2
`define CTRL_RATE_HI 1
`define CTRL_RATE_LO 0

// status register bit positions
`define STAT_DONE 7
`define STAT_WRITE_COLLISION_FLAG 6
`define STAT_MODE_FAULT_FLAG 4

// port d direction bits; bit 6 is the level of the slave select pin as a plain output
`define DDR_MISO_BIT 2
`define DDR_MOSI_BIT 3
`define DDR_SCK_BIT 4
`define DDR_SS_BIT 5
`define DDR_SS_LEVEL 6

// reset values
`define CTRL_RESET 8'h00
`define DDR_RESET 8'h40

// half sck period in clk cycles for each rate code (divide by 2, 4, 16, 32)
`define HALF_RATE0 5'h01
`define HALF_RATE1 5'h02
`define HALF_RATE2 5'h08
`define HALF_RATE3 5'h10

`endif

// ---- spi_port_pkg.sv ----
// types shared by the serial port files
package spi_port_pkg;

    typedef logic [1:0] rate_t;

    // master clock train state
    typedef enum logic {ST_IDLE, ST_RUN} mstate_e;

    typedef struct packed {
        logic irq_en;
        logic sys_en;
        logic master;
        logic clock_polarity;
        logic clock_phase;
        rate_t rate;
        logic [7:0] ddr;
        logic [7:0] sh;
        logic [7:0] rxbuf;
        logic sample;
        logic done;
        logic write_collision_flag;
        logic mode_fault_flag;
        logic done_arm;
        logic write_collision_flag_arm;
        logic mode_fault_flag_arm;
        mstate_e mst;
        logic [3:0] cnt;
        logic [4:0] div;
        logic sck_lvl;
        logic sck_q;
        logic [31:0] prdata;
    } port_state_s;

endpackage

// ---- spi_pin_sync.sv ----
// three-stage pin synchroniser with an agreement filter on the last two stages
module spi_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] pin_out
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] filt;
    } sync_s;

    sync_s st_r;
    sync_s st_nxt;

    // the first stage feeds only the second; a bit only moves once stages two and three
    // agree, which rejects a one-cycle glitch
    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_in;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        st_nxt.filt = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.filt);
    end

    // idle-high reset keeps slave select inactive
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign pin_out = st_r.filt;

endmodule // spi_pin_sync

// ---- spi_far_end.sv ----
// behavioural far-side serial device: slave to our master, master to our slave
module spi_far_end (
    input wire logic clk,
    input wire logic sck,
    input wire logic mosi,
    input wire logic miso,
    input wire logic sel,
    input wire logic clock_polarity,
    output logic sck_drv,
    output logic mosi_drv,
    output logic miso_drv,
    output logic ss_n_drv,
    output logic [7:0] rx
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] tx;

    // master side lines start released: clock at idle, select high
    initial begin
        sck_drv = 1'b0;
        mosi_drv = 1'b0;
        ss_n_drv = 1'b1;
        tx = 8'h00;
        rx = 8'h00;
    end

    // a released miso shows the inverse of its last bit, so stale data never reads as good
    assign miso_drv = sel ? tx[7] : ~tx[7];

    // slave side: sample on the leading edge, shift on the trailing edge
    always @(sck) begin
        if (sel && sck !== clock_polarity) begin
            rx = {rx[6:0], mosi};
        end else if (sel) begin
            tx = {tx[6:0], 1'b0};
        end
    end

    task automatic load(input logic [7:0] b);
        tx = b;
    endtask

    // master side, mode 0; eight clk per level because the slave synchronises its pins
    task automatic run(input logic [7:0] b, output logic [7:0] r);
        logic [7:0] s;
        s = b;
        r = 8'h00;
        @(posedge clk);
        ss_n_drv <= 1'b0;
        mosi_drv <= s[7];
        for (int i = 0; i < 8; i++) begin
            repeat (8) @(posedge clk);
            sck_drv <= 1'b1;
            r = {r[6:0], miso};
            repeat (8) @(posedge clk);
            sck_drv <= 1'b0;
            s = s << 1;
            mosi_drv <= s[7];
        end
        repeat (8) @(posedge clk);
        ss_n_drv <= 1'b1;
    endtask
endmodule // spi_far_end

// ---- testbench.sv ----
// self-checking bench: registers, master trains, mode fault and a slave transfer
`include "spi_port_params.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import spi_port_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
    logic [3:0] paddr;
    logic [31:0] pwdata, prdata;
    logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, ss_n_o, ss_n_oe;
    logic p_sck, p_mosi, p_miso, p_ss, tb_ss, far_sel, tb_clock_polarity;
    logic [7:0] far_rx;
    wire logic sck_w, mosi_w, miso_w, ss_w;
    rate_t rate_sel;
    int bad_count, samples_checked;

    // each line takes the level of whichever party enables its driver
    assign sck_w = sck_oe ? sck_o : p_sck;
    assign mosi_w = mosi_oe ? mosi_o : p_mosi;
    assign miso_w = miso_oe ? miso_o : p_miso;
    assign ss_w = ss_n_oe ? ss_n_o : (p_ss & tb_ss);

    spi_master_slave_port spi_master_slave_port_inst (.clk(clk), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sck_i(sck_w), .sck_o(sck_o), .sck_oe(sck_oe),
        .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w),
        .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(ss_w), .ss_n_o(ss_n_o),
        .ss_n_oe(ss_n_oe), .irq(irq), .rate_sel(rate_sel));

    spi_far_end spi_far_end_inst (.clk(clk), .sck(sck_w), .mosi(mosi_w), .miso(miso_w),
        .sel(far_sel), .clock_polarity(tb_clock_polarity), .sck_drv(p_sck), .mosi_drv(p_mosi),
        .miso_drv(p_miso), .ss_n_drv(p_ss), .rx(far_rx));

    // 10 MHz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // one apb transfer; pready is waited for, never assumed
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) begin
            bad_count++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
    endtask

    // status polling, bounded so a dead flag cannot hang the run
    task automatic poll(input logic [7:0] m, output logic [31:0] r);
        int n;
        n = 0;
        rd(`OFS_STAT, r);
        while ((r[7:0] & m) == 8'h00 && n < 200) begin
            rd(`OFS_STAT, r);
            n++;
        end
    endtask

    task automatic t_reset();
        logic [31:0] r;
        logic e;
        rd(`OFS_CTRL, r);
        check(r, 8'h00);
        rd(`OFS_STAT, r);
        check(r, 8'h00);
        rd(`OFS_DDR, r);
        check(r, 8'h40);
        apb(1'b0, 4'h2, 32'h0000_0000, r, e);
        check(e, 1'b1);
        check(irq, 1'b0);
    endtask

    // every rate code with polarity set, odd codes in phase one: spacing, count, idle level
    task automatic t_rates();
        logic [31:0] r;
        logic prev;
        int half, cnt, first, gap;
        wr(`OFS_DDR, 32'h0000_005C);
        for (int k = 0; k < 4; k++) begin
            half = (k == 0) ? 1 : (k == 1) ? 2 : (k == 2) ? 8 : 16;
            wr(`OFS_CTRL, 32'h0000_0058 | k | ((k & 1) << 2));
            // the idle level follows a new polarity one clock after the write
            @(posedge clk);
            @(negedge clk);
            check(sck_o, 1'b1);
            check(rate_sel, k);
            wr(`OFS_DATA, 32'h0000_0081);
            cnt = 0;
            gap = 0;
            first = 0;
            prev = sck_o;
            for (int c = 0; c < 40 * half; c++) begin
                @(negedge clk);
                if (sck_o !== prev) begin
                    cnt++;
                    if (cnt == 1) first = c;
                    if (cnt == 2) gap = c - first;
                    prev = sck_o;
                end
            end
            check(cnt, 16);
            check(gap, half);
            check({sck_oe, sck_o}, 2'b11);
            rd(`OFS_STAT, r);
            check(r, 8'h80);
            rd(`OFS_DATA, r);
            rd(`OFS_STAT, r);
            check(r, 8'h00);
        end
    endtask

    // full-duplex byte as master, with a collision before the first sck edge
    task automatic t_master();
        logic [31:0] r;
        wr(`OFS_CTRL, 32'h0000_0053);
        // sck first drops to its new idle level; the far end must not take that as a shift
        repeat (2) @(posedge clk);
        spi_far_end_inst.load(8'hA5);
        far_sel <= 1'b1;
        wr(`OFS_DATA, 32'h0000_003C);
        wr(`OFS_DATA, 32'h0000_00FF);
        poll(8'h80, r);
        check(r, 8'hC0);
        rd(`OFS_DATA, r);
        check(r, 8'hA5);
        check(far_rx, 8'h3C);
        rd(`OFS_STAT, r);
        check(r, 8'h00);
        far_sel <= 1'b0;
    endtask

    // select pulled low on an enabled master, then select as a plain output
    task automatic t_fault();
        logic [31:0] r;
        wr(`OFS_CTRL, 32'h0000_00D0);
        tb_ss <= 1'b0;
        poll(8'h10, r);
        check(r, 8'h10);
        rd(`OFS_CTRL, r);
        check(r, 8'h80);
        check({irq, sck_oe}, 2'b10);
        wr(`OFS_CTRL, 32'h0000_0000);
        rd(`OFS_STAT, r);
        check(r, 8'h00);
        check(irq, 1'b0);
        wr(`OFS_DDR, 32'h0000_007C);
        wr(`OFS_CTRL, 32'h0000_0050);
        @(negedge clk);
        check({ss_n_oe, ss_n_o}, 2'b11);
        rd(`OFS_STAT, r);
        check(r, 8'h00);
        wr(`OFS_CTRL, 32'h0000_0000);
        tb_ss <= 1'b1;
        wr(`OFS_DDR, 32'h0000_005C);
    endtask

    // slave byte clocked by the far end; rate bits set but ignored
    task automatic t_slave();
        logic [31:0] r;
        logic [7:0] b;
        wr(`OFS_CTRL, 32'h0000_0043);
        @(negedge clk);
        check({miso_oe, sck_oe}, 2'b00);
        wr(`OFS_DATA, 32'h0000_0096);
        spi_far_end_inst.run(8'h69, b);
        poll(8'h80, r);
        check(r, 8'h80);
        rd(`OFS_DATA, r);
        check(r, 8'h69);
        check(b, 8'h96);
        @(negedge clk);
        check(miso_oe, 1'b0);
        rd(`OFS_STAT, r);
        check(r, 8'h00);
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // reset for 16 cycles, then the scenarios in turn
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 4'h0;
        pwdata = 32'h0000_0000;
        tb_ss = 1'b1;
        far_sel = 1'b0;
        tb_clock_polarity = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_rates();
        t_master();
        t_fault();
        t_slave();
        wrap_up();
    end

    // watchdog: the scenarios need under a tenth of this span
    initial begin
        #2_000_000;
        bad_count++;
        wrap_up();
    end
endmodule // testbench
